// ### csfl_pkg.sv
// shared constants for the cpu status flag logic
package csfl_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFS_STATUS      = 12'h000;
   localparam logic [11:0] OFS_CORE_CTRL   = 12'h004;
   localparam logic [11:0] OFS_INT_CTRL    = 12'h008;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int ST_C       = 0;
   localparam int ST_Z       = 1;
   localparam int ST_OV      = 2;
   localparam int ST_N       = 3;
   localparam int ST_RA      = 4;
   localparam int ST_PRIO_LO = 5;
   localparam int ST_DC      = 8;
   localparam logic [15:0] ST_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // core control fields
   // ----------------------------------------------------------------
   localparam int CC_PRIO_TOP = 3;
   localparam int CC_LOOP_LO  = 8;
   localparam logic [15:0] CC_RW_MASK = 16'h18f7;
   localparam logic [15:0] CC_RESET   = 16'h0020;

   // ----------------------------------------------------------------
   // interrupt control fields
   // ----------------------------------------------------------------
   localparam int IC_NEST_DIS = 15;
   localparam logic IC_NEST_DIS_RESET = 1'b0;

   // ----------------------------------------------------------------
   // flag update mask positions
   // ----------------------------------------------------------------
   localparam int FM_C  = 0;
   localparam int FM_Z  = 1;
   localparam int FM_OV = 2;
   localparam int FM_N  = 3;
   localparam int FM_DC = 4;
   localparam int FM_W  = 5;

   // ----------------------------------------------------------------
   // priority
   // ----------------------------------------------------------------
   localparam logic [2:0] IPL_LO_MAX = 3'h7;

endpackage : csfl_pkg

// ### csfl_flag_calc.sv
// adder with result flags for byte and word operations
module csfl_flag_calc
   import csfl_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // operands
   input  wire logic [WIDTH-1:0] operand_a,
   input  wire logic [WIDTH-1:0] operand_b,
   input  wire logic             carry_in,
   input  wire logic             subtract,
   input  wire logic             byte_mode,
   // result and flags
   output logic      [WIDTH-1:0] result,
   output logic                  flag_c,
   output logic                  flag_z,
   output logic                  flag_ov,
   output logic                  flag_n,
   output logic                  flag_dc
);
   localparam int HB = WIDTH / 2;
   localparam int QB = WIDTH / 4;

   logic [WIDTH-1:0] b_eff;
   logic [WIDTH:0]   sum;
   logic [HB:0]      sum_half;
   logic [QB:0]      sum_quarter;
   logic             msb_a;
   logic             msb_b;
   logic             msb_r;
   logic             res_zero;

   // subtraction is a + ~b + carry, so carry means no borrow
   assign b_eff       = subtract ? ~operand_b : operand_b;
   assign sum         = {1'b0, operand_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, carry_in};
   assign sum_half    = {1'b0, operand_a[HB-1:0]} + {1'b0, b_eff[HB-1:0]}
                        + {{HB{1'b0}}, carry_in};
   assign sum_quarter = {1'b0, operand_a[QB-1:0]} + {1'b0, b_eff[QB-1:0]}
                        + {{QB{1'b0}}, carry_in};
   assign result      = sum[WIDTH-1:0];

   assign msb_a    = byte_mode ? operand_a[HB-1] : operand_a[WIDTH-1];
   assign msb_b    = byte_mode ? b_eff[HB-1]     : b_eff[WIDTH-1];
   assign msb_r    = byte_mode ? sum[HB-1]       : sum[WIDTH-1];
   assign res_zero = byte_mode ? (sum[HB-1:0] == '0) : (sum[WIDTH-1:0] == '0);

   assign flag_c  = byte_mode ? sum_half[HB] : sum[WIDTH];          // [RL11]
   assign flag_dc = byte_mode ? sum_quarter[QB] : sum_half[HB];     // [RL1]
   assign flag_n  = msb_r;                                          // [RL8]
   assign flag_ov = (msb_a == msb_b) && (msb_r != msb_a);           // [RL9]
   assign flag_z  = res_zero;

endmodule // csfl_flag_calc

// ### csfl_priority.sv
// forms the four-bit cpu priority level and the user interrupt block
module csfl_priority
   import csfl_pkg::*;
(
   // priority bits
   input  wire logic       top_bit,
   input  wire logic [2:0] low_bits,
   // combined view
   output logic      [3:0] level,
   output logic            user_block
);
   assign level      = {top_bit, low_bits};                         // [RL4] [RL2]
   assign user_block = top_bit | (low_bits == IPL_LO_MAX);          // [RL5] [RL3]

endmodule // csfl_priority

// ### csfl_status_flags.sv
// cpu status flags, priority level and core control registers on apb
// How it works
// (RL1) half carry is carry out of bit 4 for bytes, bit 8 for words.
// (RL2) three priority bits give the level 0 to 7 in plain binary.
// (RL3) low priority bits all ones means level 7 and no user interrupts.
// (RL4) top priority bit sits above the low three, giving levels 8 to 15.
// (RL5) top priority bit set blocks all user interrupts.
// (RL6) nesting disable set makes the low priority bits ignore software writes.
// (RL7) repeat active reads one only while a repeat loop runs.
// (RL8) negative flag follows the sign of an affecting result.
// (RL9) overflow flag marks a wrong sign flip in signed arithmetic.
// (RL10) zero flag set by zero result outside sticky mode, cleared by a later non-zero one or a status write.
// (RL11) carry flag is the carry out of the result's top bit.
// (RL12) top priority bit reads one exactly when priority is above 7.
// (RL13) unaffected flags hold; affected flags update with the result write.
module csfl_status_flags
   import csfl_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      rstn,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [csfl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // execution datapath
   input  wire logic                      alu_update,
   input  wire logic [csfl_pkg::FM_W-1:0] alu_flag_mask,
   input  wire logic                      alu_subtract,
   input  wire logic                      alu_use_carry,
   input  wire logic                      alu_zero_sticky,
   input  wire logic                      alu_byte_mode,
   input  wire logic [WIDTH-1:0]          alu_operand_a,
   input  wire logic [WIDTH-1:0]          alu_operand_b,
   output logic      [WIDTH-1:0]          alu_result,
   input  wire logic                      repeat_active_in,
   input  wire logic [2:0]                loop_nesting_level,
   input  wire logic                      ipl_load,
   input  wire logic [3:0]                ipl_load_value,
   // status towards the core
   output logic      [3:0]                priority_level,
   output logic                           user_irq_block,
   output logic                           nesting_disable_bit,
   output logic      [15:0]               cpu_status_flags
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic        c_r,  c_nxt;
   logic        z_r,  z_nxt;
   logic        ov_r, ov_nxt;
   logic        n_r,  n_nxt;
   logic        dc_r, dc_nxt;
   logic        ra_r;
   logic [2:0]  ipl_lo_r, ipl_lo_nxt;
   logic        ipl_top_r, ipl_top_nxt;
   logic [15:0] cc_rw_r, cc_rw_nxt;
   logic        nest_dis_r, nest_dis_nxt;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire logic setup_ph   = psel & ~penable;
   wire logic sw_write   = psel & penable & pready & pwrite;
   wire logic hit_status = (paddr == OFS_STATUS);
   wire logic hit_core   = (paddr == OFS_CORE_CTRL);
   wire logic hit_int    = (paddr == OFS_INT_CTRL);
   wire logic hit_any    = hit_status | hit_core | hit_int;
   wire logic wr_status  = sw_write & hit_status & ~pslverr;
   wire logic wr_core    = sw_write & hit_core & ~pslverr;
   wire logic wr_int     = sw_write & hit_int & ~pslverr;

   // ----------------------------------------------------------------
   // flag arithmetic
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] calc_result;
   logic             calc_c;
   logic             calc_z;
   logic             calc_ov;
   logic             calc_n;
   logic             calc_dc;
   wire logic        carry_in = alu_use_carry ? c_r : alu_subtract;

   csfl_flag_calc #(
      .WIDTH     (WIDTH)
   ) u_calc (
      .operand_a (alu_operand_a),
      .operand_b (alu_operand_b),
      .carry_in  (carry_in),
      .subtract  (alu_subtract),
      .byte_mode (alu_byte_mode),
      .result    (calc_result),
      .flag_c    (calc_c),
      .flag_z    (calc_z),
      .flag_ov   (calc_ov),
      .flag_n    (calc_n),
      .flag_dc   (calc_dc)
   );

   // the datapath wins over a software write to the same flag in one cycle
   function automatic logic flag_next(input logic cur, input logic hw_en,
                                      input logic hw_val, input logic sw_en,
                                      input logic sw_val);
      flag_next = hw_en ? hw_val : (sw_en ? sw_val : cur);
   endfunction

   wire logic upd_c  = alu_update & alu_flag_mask[FM_C];
   wire logic upd_z  = alu_update & alu_flag_mask[FM_Z];
   wire logic upd_ov = alu_update & alu_flag_mask[FM_OV];
   wire logic upd_n  = alu_update & alu_flag_mask[FM_N];
   wire logic upd_dc = alu_update & alu_flag_mask[FM_DC];

   // sticky mode lets chained multi-word ops only ever clear zero
   wire logic z_hw = alu_zero_sticky ? (z_r & calc_z) : calc_z;    // [RL10]

   assign c_nxt  = flag_next(c_r,  upd_c,  calc_c,  wr_status, pwdata[ST_C]);   // [RL11] [RL13]
   assign z_nxt  = flag_next(z_r,  upd_z,  z_hw,    wr_status, pwdata[ST_Z]);   // [RL10] [RL13]
   assign ov_nxt = flag_next(ov_r, upd_ov, calc_ov, wr_status, pwdata[ST_OV]);  // [RL9] [RL13]
   assign n_nxt  = flag_next(n_r,  upd_n,  calc_n,  wr_status, pwdata[ST_N]);   // [RL8] [RL13]
   assign dc_nxt = flag_next(dc_r, upd_dc, calc_dc, wr_status, pwdata[ST_DC]);  // [RL1] [RL13]

   // ----------------------------------------------------------------
   // priority level
   // ----------------------------------------------------------------
   wire logic ipl_lo_sw = wr_status & ~nest_dis_r;                  // [RL6]

   // a core load wins over software so an entry level is never lost
   assign ipl_lo_nxt  = ipl_load  ? ipl_load_value[2:0] :
                        ipl_lo_sw ? pwdata[ST_PRIO_LO +: 3] : ipl_lo_r;
   // software may only clear the top bit; the core sets it on a load
   assign ipl_top_nxt = ipl_load ? ipl_load_value[3] :
                        (wr_core & ~pwdata[CC_PRIO_TOP]) ? 1'b0 : ipl_top_r;   // [RL12]

   logic [3:0] level_nxt;
   logic       block_nxt;

   csfl_priority u_prio (
      .top_bit    (ipl_top_nxt),
      .low_bits   (ipl_lo_nxt),
      .level      (level_nxt),
      .user_block (block_nxt)
   );

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // loop level and top bit are merged in at read time, never stored from pwdata
   assign cc_rw_nxt    = wr_core ? (pwdata[15:0] & CC_RW_MASK) : cc_rw_r;
   assign nest_dis_nxt = wr_int  ? pwdata[IC_NEST_DIS] : nest_dis_r;

   // ----------------------------------------------------------------
   // read views
   // ----------------------------------------------------------------
   wire logic [15:0] status_view = {7'h00, dc_r, ipl_lo_r, ra_r, n_r, ov_r, z_r, c_r};
   wire logic [15:0] status_nxt  = {7'h00, dc_nxt, ipl_lo_nxt, repeat_active_in,
                                    n_nxt, ov_nxt, z_nxt, c_nxt};
   wire logic [15:0] core_view   = cc_rw_r
                                   | {5'h00, loop_nesting_level, 8'h00}
                                   | {12'h000, ipl_top_r, 3'h0};
   // only the nesting disable bit lives in the interrupt control word
   wire logic [15:0] int_view    = {nest_dis_r, 15'h0000};
   wire logic [15:0] read_mux    = hit_status ? status_view :
                                   hit_core   ? core_view   :
                                   hit_int    ? int_view    : 16'h0000;

   // ----------------------------------------------------------------
   // flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         c_r        <= ST_RESET[ST_C];
         z_r        <= ST_RESET[ST_Z];
         ov_r       <= ST_RESET[ST_OV];
         n_r        <= ST_RESET[ST_N];
         dc_r       <= ST_RESET[ST_DC];
         ra_r       <= ST_RESET[ST_RA];
         ipl_lo_r   <= ST_RESET[ST_PRIO_LO +: 3];
         ipl_top_r  <= CC_RESET[CC_PRIO_TOP];
         cc_rw_r    <= CC_RESET;
         nest_dis_r <= IC_NEST_DIS_RESET;
      end else begin
         c_r       <= c_nxt;
         z_r       <= z_nxt;
         ov_r      <= ov_nxt;
         n_r       <= n_nxt;
         dc_r      <= dc_nxt;
         ra_r      <= repeat_active_in;                              // [RL7]
         ipl_lo_r  <= ipl_lo_nxt;
         ipl_top_r <= ipl_top_nxt;
         cc_rw_r   <= cc_rw_nxt;
         nest_dis_r <= nest_dis_nxt;
      end
   end

   // status outputs towards the core are registered copies taken from the same next values
   // read data freeze at setup: a flag update in that cycle shows on the next read
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prdata              <= 32'h0000_0000;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
         alu_result          <= '0;
         priority_level      <= 4'h0;
         user_irq_block      <= 1'b0;
         nesting_disable_bit <= IC_NEST_DIS_RESET;
         cpu_status_flags    <= ST_RESET;
      end else begin
         prdata              <= setup_ph ? {16'h0000, read_mux} : prdata;
         pready              <= setup_ph;
         pslverr             <= setup_ph & ~hit_any;
         alu_result          <= alu_update ? calc_result : alu_result;
         priority_level      <= level_nxt;                           // [RL4]
         user_irq_block      <= block_nxt;                           // [RL3] [RL5]
         nesting_disable_bit <= nest_dis_nxt;
         cpu_status_flags    <= status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_dc_update;
      @(posedge clock) disable iff (!rstn)
      (alu_update && alu_flag_mask[FM_DC]) |=> (dc_r == $past(calc_dc));
   endproperty
   a_dc_update: assert property (p_dc_update) else $error("half carry not updated"); // [RL1]

   property p_level_encode;
      @(posedge clock) disable iff (!rstn)
      ipl_load |=> (priority_level == $past(ipl_load_value))
                   && ({ipl_top_r, ipl_lo_r} == priority_level);
   endproperty
   a_level_encode: assert property (p_level_encode) else $error("priority level mismatch"); // [RL2]

   property p_level7_block;
      @(posedge clock) disable iff (!rstn)
      (ipl_lo_nxt == 3'h7) |=> user_irq_block && (priority_level[2:0] == 3'h7);
   endproperty
   a_level7_block: assert property (p_level7_block) else $error("level 7 not blocking"); // [RL3]

   property p_top_level;
      @(posedge clock) disable iff (!rstn)
      ipl_top_nxt |=> (priority_level >= 4'h8);
   endproperty
   a_top_level: assert property (p_top_level) else $error("top bit level below 8"); // [RL4]

   property p_top_block;
      @(posedge clock) disable iff (!rstn)
      ipl_top_r |-> user_irq_block;
   endproperty
   a_top_block: assert property (p_top_block) else $error("top bit without block"); // [RL5]

   property p_nest_lock;
      @(posedge clock) disable iff (!rstn)
      (nest_dis_r && !ipl_load) |=> $stable(ipl_lo_r);
   endproperty
   a_nest_lock: assert property (p_nest_lock) else $error("priority written while locked"); // [RL6]

   property p_repeat_flag;
      @(posedge clock) disable iff (!rstn)
      repeat_active_in |=> cpu_status_flags[ST_RA] && ra_r;
   endproperty
   a_repeat_flag: assert property (p_repeat_flag) else $error("repeat flag missing"); // [RL7]

   property p_neg_ov;
      @(posedge clock) disable iff (!rstn)
      (alu_update && alu_flag_mask[FM_N] && alu_flag_mask[FM_OV])
      |=> (n_r == $past(calc_n)) && (ov_r == $past(calc_ov));
   endproperty
   a_neg_ov: assert property (p_neg_ov) else $error("negative or overflow wrong"); // [RL8] [RL9]

   property p_zero_clear;
      @(posedge clock) disable iff (!rstn)
      (alu_update && alu_flag_mask[FM_Z] && !calc_z) |=> !z_r;
   endproperty
   a_zero_clear: assert property (p_zero_clear) else $error("zero not cleared"); // [RL10]

   property p_carry;
      @(posedge clock) disable iff (!rstn)
      (alu_update && alu_flag_mask[FM_C]) |=> (c_r == $past(calc_c));
   endproperty
   a_carry: assert property (p_carry) else $error("carry not updated"); // [RL11]

   property p_top_read;
      @(posedge clock) disable iff (!rstn)
      1'b1 |-> (core_view[CC_PRIO_TOP] == (priority_level > 4'h7));
   endproperty
   a_top_read: assert property (p_top_read) else $error("top bit read wrong"); // [RL12]

   property p_hold;
      @(posedge clock) disable iff (!rstn)
      (!alu_update && !wr_status) |=> $stable({c_r, z_r, ov_r, n_r, dc_r});
   endproperty
   a_hold: assert property (p_hold) else $error("flag changed without cause"); // [RL13]

endmodule // csfl_status_flags

// ### csfl_dp_model.sv
// behavioural execution datapath that feeds the flag block
module csfl_dp_model (
   // clock
   input  wire logic                 clock,
   // datapath towards the flag block
   output logic                      alu_update,
   output logic [csfl_pkg::FM_W-1:0] alu_flag_mask,
   output logic                      alu_subtract,
   output logic                      alu_use_carry,
   output logic                      alu_zero_sticky,
   output logic                      alu_byte_mode,
   output logic [15:0]               alu_operand_a,
   output logic [15:0]               alu_operand_b,
   output logic                      repeat_active_in,
   output logic [2:0]                loop_nesting_level,
   output logic                      ipl_load,
   output logic [3:0]                ipl_load_value
);
   timeunit 1ns;
   timeprecision 1ps;
   import csfl_pkg::*;

   initial begin
      {alu_update, alu_subtract, alu_use_carry, alu_zero_sticky, alu_byte_mode} = 5'h00;
      {alu_flag_mask, alu_operand_a, alu_operand_b} = '0;
      {repeat_active_in, loop_nesting_level, ipl_load, ipl_load_value} = '0;
   end

   // one instruction; operands are garbled afterwards so nothing may rely on them
   task automatic op(input logic sub, input logic usec, input logic stk, input logic byt,
                     input logic [4:0] mask, input logic [15:0] a, input logic [15:0] b);
      @(posedge clock);
      {alu_update, alu_subtract, alu_use_carry, alu_zero_sticky, alu_byte_mode} <=
         {1'b1, sub, usec, stk, byt};
      alu_flag_mask <= mask;
      alu_operand_a <= a;
      alu_operand_b <= b;
      @(posedge clock);
      alu_update    <= 1'b0;
      alu_flag_mask <= 5'h1f;
      alu_operand_a <= ~a;
      alu_operand_b <= ~b;
   endtask

   task automatic load(input logic [3:0] v);
      @(posedge clock);
      ipl_load       <= 1'b1;
      ipl_load_value <= v;
      @(posedge clock);
      ipl_load       <= 1'b0;
      ipl_load_value <= ~v;
   endtask

   task automatic set_repeat(input logic v);
      @(posedge clock);
      repeat_active_in <= v;
   endtask

   task automatic set_loop(input logic [2:0] v);
      @(posedge clock);
      loop_nesting_level <= v;
   endtask
endmodule // csfl_dp_model

// ### tb.sv
// self-checking bench for the cpu status flag block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import csfl_pkg::*;

   logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdata;
   logic pready, pslverr, rerr, upd, usec, sub, stk, byt, rpt, ild, blk, nsd;
   logic [4:0]  mask;
   logic [15:0] opa, opb, res, st;
   logic [2:0]  lvl;
   logic [3:0]  ilv, plev;
   int failures = 0, tests_run = 0;

   initial begin
      forever #2.5 clock = ~clock;
   end

   csfl_status_flags #(.WIDTH(16)) i_csfl_status_flags (
      .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .alu_update(upd), .alu_flag_mask(mask), .alu_subtract(sub), .alu_use_carry(usec),
      .alu_zero_sticky(stk), .alu_byte_mode(byt), .alu_operand_a(opa), .alu_operand_b(opb),
      .alu_result(res), .repeat_active_in(rpt), .loop_nesting_level(lvl), .ipl_load(ild),
      .ipl_load_value(ilv), .priority_level(plev), .user_irq_block(blk),
      .nesting_disable_bit(nsd), .cpu_status_flags(st));

   csfl_dp_model i_csfl_dp_model (
      .clock(clock), .alu_update(upd), .alu_flag_mask(mask), .alu_subtract(sub),
      .alu_use_carry(usec), .alu_zero_sticky(stk), .alu_byte_mode(byt), .alu_operand_a(opa),
      .alu_operand_b(opb), .repeat_active_in(rpt), .loop_nesting_level(lvl),
      .ipl_load(ild), .ipl_load_value(ilv));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // setup then access; holds everything until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {psel, penable, pwrite} <= {2'b10, wr};
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk("pready_wait", 32'h1, 32'h0);
      end
      rdata = prdata;
      rerr  = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(name, exp, rdata);
      chk({name, "_err"}, 32'h00000000, {31'h00000000, rerr});
   endtask

   // one operation, then result and status image one cycle later
   task automatic flag(input string name, input logic sb, input logic uc, input logic sk,
                       input logic bm, input logic [4:0] m, input logic [15:0] a,
                       input logic [15:0] b, input logic [15:0] er, input logic [15:0] es);
      i_csfl_dp_model.op(sb, uc, sk, bm, m, a, b);
      @(negedge clock);
      chk({name, "_res"}, {16'h0000, er & (bm ? 16'h00ff : 16'hffff)},
          {16'h0000, res & (bm ? 16'h00ff : 16'hffff)});
      chk({name, "_flags"}, {16'h0000, es}, {16'h0000, st});
   endtask

   task automatic prio(input string name, input logic [3:0] el, input logic eb);
      @(negedge clock);
      chk({name, "_level"}, {28'h0000000, el}, {28'h0000000, plev});
      chk({name, "_block"}, {31'h00000000, eb}, {31'h00000000, blk});
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      #20000;
      failures++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd("status_rst", OFS_STATUS, 32'h00000000);
      rd("core_rst", OFS_CORE_CTRL, 32'h00000020);
      rd("intc_rst", OFS_INT_CTRL, 32'h00000000);
      apb(1'b0, 12'h00c, 32'h00000000);
      chk("unmapped_err", 32'h1, {31'h00000000, rerr});
      flag("w_dc", 0, 0, 0, 0, 5'h1f, 16'h00ff, 16'h0001, 16'h0100, 16'h0100);
      flag("b_dc", 0, 0, 0, 1, 5'h1f, 16'h000f, 16'h0001, 16'h0010, 16'h0100);
      flag("b_nodc", 0, 0, 0, 1, 5'h1f, 16'h0007, 16'h0001, 16'h0008, 16'h0000);
      flag("w_nodc", 0, 0, 0, 0, 5'h1f, 16'h000f, 16'h0001, 16'h0010, 16'h0000);
      flag("ov_add", 0, 0, 0, 0, 5'h1f, 16'h7fff, 16'h0001, 16'h8000, 16'h010c);
      flag("c_z", 0, 0, 0, 0, 5'h1f, 16'hffff, 16'h0001, 16'h0000, 16'h0103);
      flag("hold", 0, 0, 0, 0, 5'h00, 16'h0001, 16'h0001, 16'h0002, 16'h0103);
      flag("cin", 0, 1, 0, 0, 5'h1f, 16'h0001, 16'h0001, 16'h0003, 16'h0000);
      flag("sub_eq", 1, 0, 0, 0, 5'h1f, 16'h0005, 16'h0005, 16'h0000, 16'h0103);
      flag("z_keep", 1, 0, 1, 0, 5'h02, 16'h0003, 16'h0003, 16'h0000, 16'h0103);
      flag("z_clr", 1, 0, 1, 0, 5'h02, 16'h0003, 16'h0001, 16'h0002, 16'h0101);
      flag("borrow", 1, 0, 0, 0, 5'h09, 16'h0003, 16'h0005, 16'hfffe, 16'h0108);
      flag("ov_sub", 1, 0, 0, 0, 5'h1f, 16'h8000, 16'h0001, 16'h7fff, 16'h0005);
      i_csfl_dp_model.set_repeat(1'b1);
      rd("ra_on", OFS_STATUS, 32'h00000015);
      i_csfl_dp_model.set_repeat(1'b0);
      rd("ra_off", OFS_STATUS, 32'h00000005);
      for (int v = 0; v < 8; v++) begin
         apb(1'b1, OFS_STATUS, 32'(v) << ST_PRIO_LO);
         prio("low_prio", 4'(v), v == 7);
         rd("low_prio_rd", OFS_STATUS, 32'(v) << ST_PRIO_LO);
      end
      apb(1'b1, OFS_STATUS, 32'h0000ffff);
      rd("status_wr", OFS_STATUS, 32'h000001ef);
      apb(1'b1, OFS_INT_CTRL, 32'h00008000);
      @(negedge clock);
      chk("nsdis", 32'h1, {31'h00000000, nsd});
      apb(1'b1, OFS_STATUS, 32'h00000000);
      rd("prio_locked", OFS_STATUS, 32'h000000e0);
      apb(1'b1, OFS_INT_CTRL, 32'h00000000);
      i_csfl_dp_model.set_loop(3'h5);
      i_csfl_dp_model.load(4'hb);
      prio("top_set", 4'hb, 1'b1);
      rd("core_top", OFS_CORE_CTRL, 32'h00000528);
      rd("status_top", OFS_STATUS, 32'h00000060);
      apb(1'b1, OFS_CORE_CTRL, 32'h00000008);
      rd("core_keep", OFS_CORE_CTRL, 32'h00000508);
      apb(1'b1, OFS_CORE_CTRL, 32'h00000000);
      prio("top_clr", 4'h3, 1'b0);
      rd("core_clr", OFS_CORE_CTRL, 32'h00000500);
      apb(1'b1, OFS_CORE_CTRL, 32'h0000ffff);
      rd("core_ones", OFS_CORE_CTRL, 32'h00001df7);
      end_sim();
   end
endmodule // tb
